// ==== inc/clksyn_defines.svh ====
`ifndef CLKSYN_DEFINES_SVH
`define CLKSYN_DEFINES_SVH
// apb byte offsets
`define CS_OFF_CTRL 8'h00
`define CS_OFF_B7 8'h04
`define CS_OFF_B9 8'h08
`define CS_OFF_CLKEN 8'h0C
`define CS_OFF_TRI 8'h10
`define CS_OFF_DIV 8'h14
`define CS_OFF_WDLOAD 8'h18
`define CS_OFF_WDKICK 8'h1C
`define CS_OFF_STATUS 8'h20
`define CS_OFF_ISTAT 8'h24
`define CS_OFF_IMASK 8'h28
// ctrl, byte 7 and byte 9 fields
`define CS_CTRL_SOFT 0
`define CS_CTRL_FS_LO 1
`define CS_CTRL_ASYNC 5
`define CS_CTRL_SPR_LO 6
`define CS_CTRL_WDEN 8
`define CS_CTRL_DIVEN 9
`define CS_B7_INTC_FAST 3
`define CS_B9_HOST1_STOP 6
// interrupt bits
`define CS_IRQ_WDOG 0
`define CS_IRQ_RSTDONE 1
// reset values
`define CS_CLKEN_RST 10'h3FF
`define CS_WDLOAD_RST 16'hFFFF
`define CS_HALF_INIT 8'h08
`define CS_REF_HALF 8'h07
// timing
`define CS_PCLK_NS 10
`define CS_TICK_NS 1000
`define CS_RST_PULSE_NS 4000000
`define CS_SETTLE_CYC 4
`endif

// ==== inc/clksyn_pkg.sv ====
package clksyn_pkg;
	// one-hot power-up sequence
	typedef enum logic [2:0]
	{
		CS_ST_WAIT = 3'b001,
		CS_ST_LATCH = 3'b010,
		CS_ST_RUN = 3'b100
	} clksyn_state_t;
	// spread modes
	typedef enum logic [1:0]
	{
		CS_SPR_OFF = 2'h0,
		CS_SPR_C50 = 2'h1,
		CS_SPR_C25 = 2'h2,
		CS_SPR_DN50 = 2'h3
	} clksyn_spread_t;
endpackage

// ==== hw/clksyn_top.sv ====
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "clksyn_defines.svh"
// Contract
// [R01] watchdog expiry drives open-drain reset low for one 4 ms pulse
// [R02] watchdog expiry returns all clocks to the latched hardware select; divisor enable and trim stay as programmed
// [R03] select bits sampled from dual pins at power-up, then pins drive clocks
// [R04] sixteen frequency settings indexed by the four-bit select value
// [R05] frequency changes step gradually without glitches
// [R06] host clock 0 true and complement pair, stopped by host stop input
// [R07] host clock 1 ignores host stop while byte 9 bit 6 is zero
// [R08] interrupt-controller clock is 16.7 or 33 MHz by byte 7 bit 3
// [R09] memory clock sync or async to host, same phase as host clocks
// [R10] free bus clock keeps running, not gated by bus stop
// [R11] spread modes: centre 0.5%, centre 0.25%, down 0 to 0.5%; code adds one pclk per half period below sweep 16, 8 or 31
// [R12] per-output enable bits and tri-state or normal output mode
// [R13] step-less programming by trim plus graphics and bus divisors
// [R14] power-down low stops all clock outputs
// [R15] memory, graphics and bus stop inputs gate only their own group
// [R16] gating starts and ends only while the output is low
module clksyn_top
#(
	parameter int NCLK = 10,
	parameter int TICK_CYC = `CS_TICK_NS / `CS_PCLK_NS,
	parameter int RST_PULSE_CYC = `CS_RST_PULSE_NS / `CS_PCLK_NS
)
(
	input wire logic pclk, // 100 MHz clock
	input wire logic presetn, // async reset
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	output logic irq, // level interrupt
	input wire logic host_clk_halt_n, // host clock stop pin
	input wire logic mem_clk_halt_n, // memory clock stop pin
	input wire logic gfx_clock_halt_n, // graphics clock stop pin
	input wire logic bus_clk_halt_n, // bus clock stop pin
	input wire logic power_down_n, // power down pin
	input wire logic [3:0] freq_sel_i, // dual pins, input side
	output logic [3:0] freq_sel_o, // dual pins, output side
	output logic [3:0] freq_sel_oe, // dual pins, enable
	output logic host_clk0_true, // host clock 0
	output logic host_clk0_comp, // host clock 0 complement
	output logic host_clk1_true, // host clock 1
	output logic mem_clk_out, // memory clock
	output logic intc_clk_out, // interrupt-controller clock
	output logic [1:0] gfx_clk_out, // graphics clocks
	output logic bus_clk_free, // free running bus clock
	output logic [3:0] bus_clk_out, // gated bus clocks
	output logic [9:0] clk_oe, // per output drive enable
	output logic sys_reset_o, // open-drain reset, output
	output logic sys_reset_oe // open-drain reset, enable
);
	import clksyn_pkg::*;

	localparam int NSYNC = 9;
	localparam int TW = $clog2(TICK_CYC + 1);
	localparam int RW = $clog2(RST_PULSE_CYC + 1);
	// output slots: 0 host0 1 host1 2 mem 3 intc 4,5 gfx
	// 6 bus free 7 bus1 8 bus group 9 ref
	localparam logic [9:0] SPR_MASK = 10'h1C7;

	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] s1_q, s2_q, s3_q, pin_q;
	clksyn_state_t st_q;
	logic [2:0] settle_q;
	logic [3:0] hw_fs_q;
	logic run;
	logic [31:0] ctrl_q, b7_q, b9_q, div_q;
	logic [9:0] clken_q, tri_q;
	logic [15:0] wdload_q, wdcnt_q;
	logic [1:0] istat_q, imask_q, ev;
	logic wr, rd, kick;
	logic [TW-1:0] tick_cnt_q;
	logic tick;
	logic wd_exp;
	logic [RW-1:0] rst_cnt_q;
	logic rst_act_q, rst_done;
	logic [4:0] tri_pos_q;
	logic tri_up_q;
	logic [4:0] depth;
	logic stretch;
	logic [3:0] fs;
	logic [15:0] ratio;
	logic [7:0] tgt [NCLK];
	logic [NCLK-1:0] want, ph_q, gate_q, out_q;
	logic comp_q, comp_gate_q;

	// pins from outside pass four flops
	assign pin_raw = {freq_sel_i, power_down_n, bus_clk_halt_n,
		gfx_clock_halt_n, mem_clk_halt_n, host_clk_halt_n};
	generate
		for (genvar k = 0; k < NSYNC; k++)
		begin : g_sync
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					// idle high, so no false stop right after reset
					s1_q[k] <= 1'b1;
					s2_q[k] <= 1'b1;
					s3_q[k] <= 1'b1;
					pin_q[k] <= 1'b1;
				end
				else
				begin
					s1_q[k] <= pin_raw[k];
					s2_q[k] <= s1_q[k];
					s3_q[k] <= s2_q[k];
					// a change counts once stages two and three agree
					if (s2_q[k] == s3_q[k])
						pin_q[k] <= s3_q[k];
				end
			end
		end
	endgenerate

	// power-up latch of the select straps, then pins turn to outputs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_q <= CS_ST_WAIT;
			settle_q <= 3'h0;
			hw_fs_q <= 4'h0;
		end
		else
		begin
			case (st_q)
				CS_ST_WAIT:
				begin
					settle_q <= settle_q + 3'h1;
					if (settle_q == 3'(`CS_SETTLE_CYC))
						st_q <= CS_ST_LATCH;
				end
				CS_ST_LATCH:
				begin
					hw_fs_q <= pin_q[8:5]; // [R03]
					st_q <= CS_ST_RUN;
				end
				default: st_q <= CS_ST_RUN;
			endcase
		end
	end
	assign run = (st_q == CS_ST_RUN);

	// apb: zero wait states, unmapped addresses answer with an error
	assign pready = 1'b1;
	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	assign kick = wr && (paddr == `CS_OFF_WDKICK);
	always_comb
	begin
		prdata = 32'h0;
		pslverr = 1'b0;
		if (paddr == `CS_OFF_CTRL)
			prdata = ctrl_q;
		else if (paddr == `CS_OFF_B7)
			prdata = b7_q;
		else if (paddr == `CS_OFF_B9)
			prdata = b9_q;
		else if (paddr == `CS_OFF_CLKEN)
			prdata = {22'h0, clken_q};
		else if (paddr == `CS_OFF_TRI)
			prdata = {22'h0, tri_q};
		else if (paddr == `CS_OFF_DIV)
			prdata = div_q;
		else if (paddr == `CS_OFF_WDLOAD)
			prdata = {16'h0, wdload_q};
		else if (paddr == `CS_OFF_WDKICK)
			prdata = {16'h0, wdcnt_q};
		else if (paddr == `CS_OFF_STATUS)
			prdata = {25'h0, ctrl_q[`CS_CTRL_SOFT], rst_act_q, run, hw_fs_q};
		else if (paddr == `CS_OFF_ISTAT)
			prdata = {30'h0, istat_q};
		else if (paddr == `CS_OFF_IMASK)
			prdata = {30'h0, imask_q};
		else
			pslverr = psel && penable;
	end

	// control registers; expiry drops back to the strap select
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q <= 32'h0;
			b7_q <= 32'h0;
			b9_q <= 32'h0;
			clken_q <= `CS_CLKEN_RST;
			tri_q <= 10'h0;
			div_q <= 32'h0;
			wdload_q <= `CS_WDLOAD_RST;
			imask_q <= 2'h0;
		end
		else
		begin
			if (wr && paddr == `CS_OFF_CTRL)
				ctrl_q <= {22'h0, pwdata[9:0]};
			if (wr && paddr == `CS_OFF_B7)
				b7_q <= {24'h0, pwdata[7:0]};
			if (wr && paddr == `CS_OFF_B9)
				b9_q <= {24'h0, pwdata[7:0]};
			if (wr && paddr == `CS_OFF_CLKEN)
				clken_q <= pwdata[9:0]; // [R12]
			if (wr && paddr == `CS_OFF_TRI)
				tri_q <= pwdata[9:0]; // [R12]
			if (wr && paddr == `CS_OFF_DIV)
				div_q <= {12'h0, pwdata[19:0]}; // [R13]
			if (wr && paddr == `CS_OFF_WDLOAD)
				wdload_q <= pwdata[15:0];
			if (wr && paddr == `CS_OFF_IMASK)
				imask_q <= pwdata[1:0];
			if (wd_exp)
				ctrl_q[`CS_CTRL_SOFT] <= 1'b0; // [R02]
		end
	end

	// 1 us tick shared by watchdog and spread profile
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tick_cnt_q <= '0;
		else if (tick)
			tick_cnt_q <= '0;
		else
			tick_cnt_q <= tick_cnt_q + 1'b1;
	end
	assign tick = (tick_cnt_q == TW'(TICK_CYC - 1));

	// watchdog in us ticks; a kick or a disable reloads it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wdcnt_q <= `CS_WDLOAD_RST;
		else if (kick || !ctrl_q[`CS_CTRL_WDEN] || wd_exp)
			wdcnt_q <= wdload_q;
		else if (tick)
			wdcnt_q <= wdcnt_q - 16'h1;
	end
	assign wd_exp = ctrl_q[`CS_CTRL_WDEN] && tick && wdcnt_q == 16'h0
		&& !kick;

	// single low pulse; a second expiry inside it restarts the count
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rst_act_q <= 1'b0;
			rst_cnt_q <= '0;
		end
		else if (wd_exp)
		begin
			rst_act_q <= 1'b1; // [R01]
			rst_cnt_q <= '0;
		end
		else if (rst_act_q)
		begin
			rst_cnt_q <= rst_cnt_q + 1'b1;
			if (rst_done)
				rst_act_q <= 1'b0; // [R01]
		end
	end
	assign rst_done = rst_act_q && rst_cnt_q == RW'(RST_PULSE_CYC - 1);
	assign sys_reset_o = 1'b0;
	assign sys_reset_oe = rst_act_q; // [R01]

	// sticky events, write one to clear, a new event beats the clear
	assign ev = {rst_done, wd_exp};
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			istat_q <= 2'h0;
		else if (wr && paddr == `CS_OFF_ISTAT)
			istat_q <= (istat_q & ~pwdata[1:0]) | ev;
		else
			istat_q <= istat_q | ev;
	end
	assign irq = |(istat_q & imask_q);

	// triangular profile; depth sets how often a period is stretched
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tri_pos_q <= 5'h0;
			tri_up_q <= 1'b1;
		end
		else if (tick)
		begin
			tri_pos_q <= tri_up_q ? tri_pos_q + 5'h1 : tri_pos_q - 5'h1;
			if (tri_pos_q == 5'h1E && tri_up_q)
				tri_up_q <= 1'b0;
			else if (tri_pos_q == 5'h01 && !tri_up_q)
				tri_up_q <= 1'b1;
		end
	end
	// limitation: one pclk of stretch is far coarser than 0.5%, so the
	// modes only differ in how much of the sweep is stretched
	always_comb
	begin
		case (clksyn_spread_t'(ctrl_q[`CS_CTRL_SPR_LO +: 2])) // [R11]
			CS_SPR_C50: depth = 5'h10;
			CS_SPR_C25: depth = 5'h08;
			CS_SPR_DN50: depth = 5'h1F;
			default: depth = 5'h00;
		endcase
	end
	assign stretch = tri_pos_q < depth;

	// ratio table {host, mem, bus, gfx}, one entry per select value
	assign fs = ctrl_q[`CS_CTRL_SOFT] ? ctrl_q[`CS_CTRL_FS_LO +: 4]
		: hw_fs_q; // [R02]
	always_comb
	begin
		case (fs) // [R04]
			4'h0: ratio = 16'h6626;
			4'h1: ratio = 16'h4436;
			4'h2: ratio = 16'h3358;
			4'h3: ratio = 16'h3346;
			4'h4: ratio = 16'h6426;
			4'h5: ratio = 16'h4636;
			4'h6: ratio = 16'h4336;
			4'h7: ratio = 16'h3446;
			4'h8: ratio = 16'h3335;
			4'h9: ratio = 16'h3346;
			4'hA: ratio = 16'h3346;
			4'hB: ratio = 16'h2255;
			4'hC: ratio = 16'h6326;
			4'hD: ratio = 16'h4348;
			4'hE: ratio = 16'h2355;
			default: ratio = 16'h3458;
		endcase
	end

	// half periods in pclk cycles; trim scales like a slower oscillator
	always_comb
	begin
		logic [7:0] trim, bus_h;
		trim = {5'h0, div_q[18:16]};
		bus_h = 8'(ratio[15:12] * ratio[7:4]);
		if (ctrl_q[`CS_CTRL_DIVEN])
			bus_h = div_q[15:8]; // [R13]
		tgt[0] = {4'h0, ratio[15:12]} + trim;
		tgt[1] = tgt[0];
		// sync mode follows host ratio, async uses memory ratio
		tgt[2] = (ctrl_q[`CS_CTRL_ASYNC] ? {4'h0, ratio[11:8]}
			: {4'h0, ratio[15:12]}) + trim; // [R09]
		tgt[3] = b7_q[`CS_B7_INTC_FAST] ? bus_h + trim
			: 8'((bus_h + trim) << 1); // [R08]
		tgt[4] = (ctrl_q[`CS_CTRL_DIVEN] ? div_q[7:0]
			: {4'h0, ratio[3:0]}) + trim; // [R13]
		tgt[5] = tgt[4];
		tgt[6] = bus_h + trim;
		tgt[7] = tgt[6];
		tgt[8] = tgt[6];
		tgt[9] = `CS_REF_HALF;
	end

	// gating wishes per slot
	always_comb
	begin
		logic pd;
		pd = pin_q[4];
		want[0] = pin_q[0]; // [R06]
		want[1] = b9_q[`CS_B9_HOST1_STOP] ? pin_q[0] : 1'b1; // [R07]
		want[2] = pin_q[1]; // [R15]
		want[3] = 1'b1;
		want[4] = pin_q[2]; // [R15]
		want[5] = pin_q[2];
		want[6] = 1'b1; // [R10]
		want[7] = pin_q[3]; // [R15]
		want[8] = pin_q[3];
		want[9] = 1'b1;
		want = want & clken_q & {NCLK{pd}}; // [R12] [R14]
	end

	// all generators start together, so host and memory share phase
	generate
		for (genvar i = 0; i < NCLK; i++)
		begin : g_clk
			logic [7:0] cnt_q, half_q;
			logic [7:0] lim;
			assign lim = half_q - 8'h1 + ((SPR_MASK[i] && stretch)
				? 8'h1 : 8'h0);
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					cnt_q <= 8'h0;
					half_q <= `CS_HALF_INIT;
					ph_q[i] <= 1'b0;
				end
				else if (run && cnt_q >= lim)
				begin
					cnt_q <= 8'h0;
					ph_q[i] <= ~ph_q[i];
					// one cycle step per period, never a jump
					if (ph_q[i] && half_q < tgt[i])
						half_q <= half_q + 8'h1; // [R05]
					else if (ph_q[i] && half_q > tgt[i] && half_q > 8'h1)
						half_q <= half_q - 8'h1; // [R05]
				end
				else if (run)
					cnt_q <= cnt_q + 8'h1;
			end
			// the gate only moves during the low half, no runt pulses
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					gate_q[i] <= 1'b0;
				else if (!ph_q[i])
					gate_q[i] <= want[i]; // [R16]
			end
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					out_q[i] <= 1'b0;
				else
					out_q[i] <= ph_q[i] & gate_q[i];
			end
		end
	endgenerate

	// complement has its own gate, moved only while the complement is low
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			comp_gate_q <= 1'b0;
		else if (ph_q[0])
			comp_gate_q <= want[0]; // [R16]
	end

	// complement stops low together with the true output
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			comp_q <= 1'b0;
		else
			comp_q <= ~ph_q[0] & comp_gate_q & run; // [R06]
	end

	assign host_clk0_true = out_q[0];
	assign host_clk0_comp = comp_q;
	assign host_clk1_true = out_q[1];
	assign mem_clk_out = out_q[2];
	assign intc_clk_out = out_q[3];
	assign gfx_clk_out = out_q[5:4];
	assign bus_clk_free = out_q[6];
	assign bus_clk_out = {out_q[8], out_q[8], out_q[8], out_q[7]};
	assign clk_oe = run ? ~tri_q : 10'h0; // [R12]
	// strap pins stay undriven until the select has been captured
	assign freq_sel_o = {out_q[7], out_q[6], out_q[9], out_q[9]};
	assign freq_sel_oe = run ? {~tri_q[7], ~tri_q[6], ~tri_q[9], ~tri_q[9]}
		: 4'h0; // [R03]
endmodule

// ==== testbench/clksyn_board_model.sv ====
`timescale 1ns/1ps
module clksyn_board_model
(
	input wire logic [3:0] strap, // board strap levels
	input wire logic [3:0] freq_sel_o, // device pin data
	input wire logic [3:0] freq_sel_oe, // device pin enable
	output logic [3:0] freq_sel_i, // resolved pin level
	input wire logic sys_reset_o, // reset pin data
	input wire logic sys_reset_oe, // reset pin enable
	output logic reset_line_n // pulled-up reset wire
);
	// an undriven strap pin settles to the board strap resistor
	always_comb
		for (int i = 0; i < 4; i++)
			freq_sel_i[i] = freq_sel_oe[i] ? freq_sel_o[i] : strap[i];
	// open drain: only a low is driven, the pull-up does the rest
	assign reset_line_n = sys_reset_oe ? sys_reset_o : 1'b1;
endmodule

// ==== testbench/clksyn_props.sv ====
`timescale 1ns/1ps
module clksyn_props
#(
	parameter int RST_PULSE_CYC = 400000
)
(
	input wire logic pclk, // clock
	input wire logic presetn, // async reset
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic [7:0] paddr, // apb address
	input wire logic pready, // apb ready
	input wire logic pslverr, // apb error
	input wire logic host_clk_halt_n, // host stop
	input wire logic power_down_n, // power down
	input wire logic [3:0] freq_sel_oe, // strap pin enable
	input wire logic host_clk0_true, // host clock 0
	input wire logic host_clk0_comp, // host clock 0 complement
	input wire logic host_clk1_true, // host clock 1
	input wire logic mem_clk_out, // memory clock
	input wire logic intc_clk_out, // interrupt-controller clock
	input wire logic [1:0] gfx_clk_out, // graphics clocks
	input wire logic bus_clk_free, // free bus clock
	input wire logic [3:0] bus_clk_out, // gated bus clocks
	input wire logic sys_reset_o, // reset pin data
	input wire logic sys_reset_oe // reset pin enable
);
	logic [31:0] pulse_q;
	logic [5:0] hs_q, pd_q;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// length of the running reset pulse; wide since the real one is long
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			pulse_q <= 32'h0;
		else
			pulse_q <= sys_reset_oe ? pulse_q + 32'h1 : 32'h0;
	// cycles a stop input has been low, saturating
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			hs_q <= 6'h0;
			pd_q <= 6'h0;
		end
		else
		begin
			hs_q <= host_clk_halt_n ? 6'h0 : hs_q + {5'h0, hs_q != 6'h3F};
			pd_q <= power_down_n ? 6'h0 : pd_q + {5'h0, pd_q != 6'h3F};
		end
	a_pulse_len: assert property ($fell(sys_reset_oe) |->
		pulse_q == RST_PULSE_CYC) else $error("reset pulse length wrong");
	a_od_low: assert property (sys_reset_oe |-> !sys_reset_o)
		else $error("reset pin driven high");
	a_strap_wait: assert property ($rose(presetn) |->
		(freq_sel_oe == 4'h0) [*4]) else $error("strap pin driven early");
	a_pair_excl: assert property (!(host_clk0_true && host_clk0_comp))
		else $error("host pair both high");
	a_host_stop: assert property (hs_q >= 6'd60 |->
		!host_clk0_true && !host_clk0_comp) else $error("host not stopped");
	a_pd_stop: assert property (pd_q >= 6'd60 |-> {host_clk0_true,
		host_clk0_comp, host_clk1_true, mem_clk_out, intc_clk_out,
		gfx_clk_out, bus_clk_free, bus_clk_out} == 12'h0)
		else $error("clock runs in power down");
	a_host_runt: assert property ($rose(host_clk0_true) |=> host_clk0_true)
		else $error("short host pulse");
	a_free_runt: assert property ($rose(bus_clk_free) |->
		##1 $stable(bus_clk_free)) else $error("short bus pulse");
	a_unmapped_err: assert property (psel && penable && paddr > 8'h28 |->
		pslverr && pready) else $error("unmapped access not refused");
	c_pulse: cover property ($fell(sys_reset_oe));
	c_host_stop: cover property (hs_q == 6'd60);
	c_pd: cover property (pd_q == 6'd60);
endmodule
bind clksyn_top clksyn_props #(.RST_PULSE_CYC(RST_PULSE_CYC)) props_i
(
	.pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr,
	.host_clk_halt_n, .power_down_n, .freq_sel_oe, .host_clk0_true,
	.host_clk0_comp, .host_clk1_true, .mem_clk_out, .intc_clk_out,
	.gfx_clk_out, .bus_clk_free, .bus_clk_out, .sys_reset_o, .sys_reset_oe
);

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
`include "clksyn_defines.svh"
`define CHK(g, e) \
	begin \
		samples_checked++; \
		if ((g) !== (e)) \
		begin \
			error_cnt++; \
			$display("BAD %0t got %0h want %0h", $time, g, e); \
		end \
	end
module tb;
	localparam int RPC = 50;
	localparam logic [3:0] STRAP = 4'h5;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, irq, err, reset_line_n;
	logic host_clk_halt_n = 1, mem_clk_halt_n = 1, gfx_clock_halt_n = 1;
	logic bus_clk_halt_n = 1, power_down_n = 1;
	logic [3:0] freq_sel_i, freq_sel_o, freq_sel_oe, bus_clk_out;
	logic host_clk0_true, host_clk0_comp, host_clk1_true, mem_clk_out;
	logic intc_clk_out, bus_clk_free, sys_reset_o, sys_reset_oe;
	logic [1:0] gfx_clk_out;
	logic [9:0] clk_oe;
	int error_cnt = 0, samples_checked = 0;
	int tg [7];
	wire [6:0] clkv = {gfx_clk_out[0], mem_clk_out, bus_clk_out[0],
		intc_clk_out, bus_clk_free, host_clk1_true, host_clk0_true};
	always #5 pclk = ~pclk;
	clksyn_top #(.TICK_CYC(4), .RST_PULSE_CYC(RPC)) dut
	(
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .irq, .host_clk_halt_n, .mem_clk_halt_n,
		.gfx_clock_halt_n, .bus_clk_halt_n, .power_down_n, .freq_sel_i,
		.freq_sel_o, .freq_sel_oe, .host_clk0_true, .host_clk0_comp,
		.host_clk1_true, .mem_clk_out, .intc_clk_out, .gfx_clk_out,
		.bus_clk_free, .bus_clk_out, .clk_oe, .sys_reset_o, .sys_reset_oe
	);
	clksyn_board_model board
	(
		.strap(STRAP), .freq_sel_o, .freq_sel_oe, .freq_sel_i,
		.sys_reset_o, .sys_reset_oe, .reset_line_n
	);
	// one apb transfer; read data and error land in rd and err
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// toggle counts per clock after a settle time long enough for gating
	task automatic count(input int n);
		logic [6:0] p;
		repeat (40) @(posedge pclk);
		tg = '{default: 0};
		p = clkv;
		repeat (n)
		begin
			@(posedge pclk);
			for (int i = 0; i < 7; i++)
				tg[i] += int'(clkv[i] != p[i]);
			p = clkv;
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic t_regs();
		apb(0, `CS_OFF_CLKEN, 0);
		`CHK(rd[9:0], `CS_CLKEN_RST)
		apb(0, `CS_OFF_TRI, 0);
		`CHK(rd[9:0], 10'h000)
		apb(0, `CS_OFF_STATUS, 0);
		`CHK(rd[6:0], {3'b001, STRAP})
		`CHK(freq_sel_oe, 4'hF)
		apb(1, 8'h40, 32'hFFFFFFFF);
		`CHK(err, 1'b1)
		apb(0, 8'h40, 0);
		`CHK({err, rd}, {1'b1, 32'h0})
		$display("done regs");
	endtask
	task automatic t_tri();
		apb(1, `CS_OFF_TRI, 32'h005);
		@(posedge pclk);
		@(posedge pclk);
		`CHK(clk_oe, 10'h3FA)
		apb(1, `CS_OFF_TRI, 0);
		apb(1, `CS_OFF_CLKEN, 32'h3FE);
		count(60);
		`CHK(tg[0], 0)
		`CHK(tg[1] > 0, 1'b1)
		apb(1, `CS_OFF_CLKEN, 32'h3FF);
		$display("done enables");
	endtask
	task automatic t_host();
		apb(1, `CS_OFF_B9, 0);
		host_clk_halt_n <= 1'b0;
		count(60);
		`CHK(tg[0], 0)
		`CHK(tg[1] > 0, 1'b1)
		apb(1, `CS_OFF_B9, 32'h40);
		count(60);
		`CHK(tg[1], 0)
		host_clk_halt_n <= 1'b1;
		apb(1, `CS_OFF_B9, 0);
		count(60);
		`CHK(tg[0] > 0, 1'b1)
		$display("done host stop");
	endtask
	task automatic t_groups();
		bus_clk_halt_n <= 1'b0;
		count(60);
		`CHK({tg[4] == 0, tg[2] > 0, tg[5] > 0}, 3'b111)
		bus_clk_halt_n <= 1'b1;
		mem_clk_halt_n <= 1'b0;
		count(60);
		`CHK({tg[5] == 0, tg[4] > 0, tg[6] > 0}, 3'b111)
		mem_clk_halt_n <= 1'b1;
		gfx_clock_halt_n <= 1'b0;
		count(60);
		`CHK({tg[6] == 0, tg[5] > 0, tg[0] > 0}, 3'b111)
		gfx_clock_halt_n <= 1'b1;
		$display("done groups");
	endtask
	task automatic t_pd();
		power_down_n <= 1'b0;
		count(60);
		for (int i = 0; i < 7; i++)
			`CHK(tg[i], 0)
		`CHK({freq_sel_o, gfx_clk_out, bus_clk_out, host_clk0_comp}, 11'h0)
		power_down_n <= 1'b1;
		count(60);
		`CHK(tg[0] > 0, 1'b1)
		$display("done power down");
	endtask
	task automatic t_intc();
		apb(1, `CS_OFF_B7, 32'h08);
		// the half period walks one step per period, let it arrive
		repeat (500) @(posedge pclk);
		count(240);
		`CHK((tg[3] - tg[2]) inside {[-2:2]}, 1'b1)
		apb(1, `CS_OFF_B7, 0);
		repeat (500) @(posedge pclk);
		count(240);
		`CHK((2 * tg[3] - tg[2]) inside {[-3:3]}, 1'b1)
		$display("done intc");
	endtask
	// select 5: host half 4, async memory half 6, then divisor and spread
	task automatic t_ratio();
		apb(1, `CS_OFF_CTRL, 32'h2B);
		repeat (100) @(posedge pclk);
		count(240);
		`CHK((2 * tg[0] - 3 * tg[5]) inside {[-5:5]}, 1'b1)
		apb(1, `CS_OFF_DIV, 32'h0503);
		apb(1, `CS_OFF_CTRL, 32'h2CB);
		repeat (100) @(posedge pclk);
		count(240);
		`CHK(tg[6] inside {[78:82]}, 1'b1)
		`CHK(tg[0] inside {[45:51]}, 1'b1)
		apb(1, `CS_OFF_CTRL, 0);
		$display("done ratio");
	endtask
	task automatic t_wdog();
		int n;
		apb(1, `CS_OFF_IMASK, 0);
		apb(1, `CS_OFF_WDLOAD, 32'd20);
		apb(1, `CS_OFF_WDKICK, 0);
		apb(1, `CS_OFF_CTRL, 32'h115);
		apb(0, `CS_OFF_STATUS, 0);
		`CHK(rd[6], 1'b1)
		while (sys_reset_oe !== 1'b1)
			@(posedge pclk);
		`CHK(reset_line_n, 1'b0)
		n = 0;
		while (sys_reset_oe === 1'b1)
		begin
			@(posedge pclk);
			n++;
		end
		`CHK(n, RPC)
		// read before software touches the control word again
		apb(0, `CS_OFF_STATUS, 0);
		`CHK(rd[6:0], {3'b001, STRAP})
		apb(1, `CS_OFF_CTRL, 0);
		apb(0, `CS_OFF_ISTAT, 0);
		`CHK({rd[1:0], irq}, 3'b110)
		apb(1, `CS_OFF_IMASK, 32'h3);
		@(posedge pclk);
		`CHK(irq, 1'b1)
		apb(1, `CS_OFF_ISTAT, 32'h1);
		@(posedge pclk);
		`CHK(irq, 1'b1)
		apb(1, `CS_OFF_ISTAT, 32'h2);
		@(posedge pclk);
		`CHK(irq, 1'b0)
		$display("done watchdog");
	endtask
	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		repeat (10) @(posedge pclk);
		t_regs();
		t_tri();
		t_host();
		t_groups();
		t_pd();
		t_intc();
		t_ratio();
		t_wdog();
		finish_test();
	end
	// the sequence needs a few thousand cycles; this cuts a hang short
	initial
	begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		finish_test();
	end
endmodule
